/* File: hw/sps_supervisor.sv */
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sps_params.svh"
// Functional notes
// - Raise software limit alarm when motor leaves command range widened by working range.
// - Limit check works only in position or full-closed control mode.
// - Limit check works only while servo is on.
// - With no commands, range is working range on both sides of reference.
// - Commands either way widen accumulated range; limits add working range each side.
// - On limit alarm, request stop using the alarm stop sequence setting.
// - Limit protection is suppressed during tool trial run or frequency measurement; code gates it on tool_test_i only.
// - Command range clears at reset, deviation clear, overtravel clear, trial start/end.
// - Immediate-stop alarm with falling prevention drops brake release, holds current.
// - Hold time counts in 2 ms steps; zero disables falling prevention.
// - Falling prevention needs sequence 4 and expansion bit10; bit10 clears deviation.
// - Sequence values 4 to 7 select immediate stop for supporting alarms.
// - Warnings follow their cause and clear automatically unless latched.
// - Latched warnings hold 1 to 10 s or forever; battery, lifetime forever.
// - While alarm clear input is asserted, all warnings stay cleared.
// - Overload and regeneration warnings at load factor 85 percent or more.
// - Fan warning after 1 s stopped, not for intentional upper fan stop.
// - Communication warnings when consecutive error count exceeds its threshold.
// - Encoder overheat, oscillation and scale error are separate warning codes.
module sps_supervisor
	import sps_pkg::*;
#(
	parameter int unsigned HOLD_STEP_CYC = `SPS_MS_CYC(`SPS_HOLD_STEP_MS),
	parameter int unsigned FAN_STOP_CYC = `SPS_MS_CYC(`SPS_FAN_STOP_MS),
	parameter int unsigned LATCH_UNIT_CYC = `SPS_MS_CYC(`SPS_LATCH_UNIT_MS)
) (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Drive state from control logic.
	input wire sps_cmd_t cmd_i,
	input wire logic signed [31:0] motor_pos_i,
	input wire logic servo_on_i,
	input wire logic [1:0] control_mode_i,
	input wire logic tool_test_i,
	input wire logic trial_run_i,
	input wire logic imm_alarm_i,
	input wire sps_cause_t cause_i,
	// Asynchronous pins.
	input wire logic alarm_clear_in_i,
	input wire logic dev_clear_in_i,
	input wire logic ot_inhibit_in_i,
	// Protection outputs.
	output logic software_limit_alarm_o,
	output logic stop_request_o,
	output logic [2:0] stop_mode_o,
	output logic immediate_stop_o,
	output logic brake_release_out_o,
	output logic motor_current_on_o,
	output logic deviation_clear_o,
	output logic [9:0] warnings_o,
	output logic warning_active_o,
	output logic [3:0] warning_code_o
);

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] count_err(input logic [7:0] cnt, input logic err, input logic ok);
		logic [7:0] r;
		r = cnt;
		if (ok) begin
			r = 8'h00;
		end else if (err && cnt != 8'hFF) begin
			r = cnt + 8'h01;
		end
		return r;
	endfunction

	// ****************************************************************
	// Pin synchronisers.
	// ****************************************************************
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic alarm_clear;
	logic dev_clear;
	logic ot_inhibit;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else if (ce_i) begin
			pin_meta <= {ot_inhibit_in_i, dev_clear_in_i, alarm_clear_in_i};
			pin_sync <= pin_meta;
		end
	end

	assign alarm_clear = pin_sync[0];
	assign dev_clear = pin_sync[1];
	assign ot_inhibit = pin_sync[2];

	// ****************************************************************
	// Register file.
	// ****************************************************************
	logic [31:0] work_range;
	logic [31:0] sequence_reg;
	logic [15:0] function_expansion_setup;
	logic [15:0] brake_hold_wait_time;
	logic [31:0] warn_latch_reg;
	logic [15:0] oscillation_detect_level;
	logic [15:0] comm_limit;
	logic [2:0] alarm_stop_sequence;
	logic [2:0] overtravel_stop_sequence;
	logic [3:0] warning_latch_time;
	logic [9:0] latch_mask;
	logic wb_req;
	logic [31:0] next_rdata;
	logic signed [31:0] cmd_min;
	logic signed [31:0] cmd_max;
	sps_brake_t brake_state;

	assign wb_req = wb_cyc_i && wb_stb_i;
	assign alarm_stop_sequence = sequence_reg[`SPS_SEQ_ALARM_LSB +: 3];
	assign overtravel_stop_sequence = sequence_reg[`SPS_SEQ_OT_LSB +: 3];
	assign warning_latch_time = warn_latch_reg[3:0];
	assign latch_mask = warn_latch_reg[`SPS_LATCH_MASK_LSB +: 10];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			work_range <= `SPS_RST_WORK_RANGE;
			sequence_reg <= `SPS_RST_SEQUENCE;
			function_expansion_setup <= `SPS_RST_EXPANSION;
			brake_hold_wait_time <= `SPS_RST_BRAKE_HOLD;
			warn_latch_reg <= `SPS_RST_WARN_LATCH;
			oscillation_detect_level <= `SPS_RST_OSC_LEVEL;
			comm_limit <= `SPS_RST_COMM_LIMIT;
		end else if (ce_i && wb_req && wb_we_i && wb_ack_o) begin
			unique case (wb_adr_i)
				`SPS_ADR_WORK_RANGE: work_range <= merge_bytes(work_range, wb_dat_i, wb_sel_i);
				`SPS_ADR_SEQUENCE: sequence_reg <= merge_bytes(sequence_reg, wb_dat_i, wb_sel_i) & 32'h0000_0077;
				`SPS_ADR_EXPANSION: function_expansion_setup <=
					16'(merge_bytes({16'h0000, function_expansion_setup}, wb_dat_i, wb_sel_i));
				`SPS_ADR_BRAKE_HOLD: brake_hold_wait_time <=
					16'(merge_bytes({16'h0000, brake_hold_wait_time}, wb_dat_i, wb_sel_i));
				`SPS_ADR_WARN_LATCH: warn_latch_reg <= merge_bytes(warn_latch_reg, wb_dat_i, wb_sel_i) & 32'h03FF_000F;
				`SPS_ADR_OSC_LEVEL: oscillation_detect_level <=
					16'(merge_bytes({16'h0000, oscillation_detect_level}, wb_dat_i, wb_sel_i));
				`SPS_ADR_COMM_LIMIT: comm_limit <= 16'(merge_bytes({16'h0000, comm_limit}, wb_dat_i, wb_sel_i));
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			`SPS_ADR_WORK_RANGE: next_rdata = work_range;
			`SPS_ADR_SEQUENCE: next_rdata = sequence_reg;
			`SPS_ADR_EXPANSION: next_rdata = {16'h0000, function_expansion_setup};
			`SPS_ADR_BRAKE_HOLD: next_rdata = {16'h0000, brake_hold_wait_time};
			`SPS_ADR_WARN_LATCH: next_rdata = warn_latch_reg;
			`SPS_ADR_OSC_LEVEL: next_rdata = {16'h0000, oscillation_detect_level};
			`SPS_ADR_COMM_LIMIT: next_rdata = {16'h0000, comm_limit};
			`SPS_ADR_STATUS: next_rdata = {6'h00, warnings_o, 10'h000, deviation_clear_o, motor_current_on_o,
				brake_release_out_o, immediate_stop_o, stop_request_o, software_limit_alarm_o};
			`SPS_ADR_CMD_MIN: next_rdata = cmd_min;
			`SPS_ADR_CMD_MAX: next_rdata = cmd_max;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Ack follows one cycle after the request and drops in the next.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req && !wb_ack_o;
			if (wb_req && !wb_ack_o) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// ****************************************************************
	// Command range tracking.
	// ****************************************************************
	logic signed [31:0] cmd_pos;
	logic signed [31:0] next_cmd_pos;
	logic trial_prev;
	logic range_clear;

	assign range_clear = dev_clear || (overtravel_stop_sequence == `SPS_OT_CLEAR_SEQ && ot_inhibit) ||
		(trial_run_i != trial_prev);
	assign next_cmd_pos = cmd_pos + 32'(cmd_i.delta);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trial_prev <= 1'b0;
		end else if (ce_i) begin
			trial_prev <= trial_run_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && range_clear)) begin
			cmd_pos <= 32'h0000_0000;
			cmd_min <= 32'h0000_0000;
			cmd_max <= 32'h0000_0000;
		end else if (ce_i && cmd_i.valid) begin
			cmd_pos <= next_cmd_pos;
			if (next_cmd_pos < cmd_min) begin
				cmd_min <= next_cmd_pos;
			end
			if (next_cmd_pos > cmd_max) begin
				cmd_max <= next_cmd_pos;
			end
		end
	end

	// ****************************************************************
	// Software limit and stop request.
	// ****************************************************************
	logic signed [33:0] lim_lo;
	logic signed [33:0] lim_hi;
	logic signed [33:0] pos_ext;
	logic limit_enable;
	logic limit_hit;
	logic imm_event;
	logic fall_enable;

	assign lim_lo = 34'(cmd_min) - $signed({2'b00, work_range});
	assign lim_hi = 34'(cmd_max) + $signed({2'b00, work_range});
	assign pos_ext = 34'(motor_pos_i);
	assign limit_enable = servo_on_i && !tool_test_i &&
		(control_mode_i == `SPS_MODE_POSITION || control_mode_i == `SPS_MODE_FULL_CLOSED);
	assign limit_hit = limit_enable && (pos_ext > lim_hi || pos_ext < lim_lo);
	assign imm_event = (limit_hit && !software_limit_alarm_o) || imm_alarm_i;
	assign fall_enable = alarm_stop_sequence == `SPS_FALL_SEQ &&
		function_expansion_setup[`SPS_EXP_FALL_BIT] && brake_hold_wait_time != 16'h0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			software_limit_alarm_o <= 1'b0;
			stop_request_o <= 1'b0;
			stop_mode_o <= 3'h0;
			immediate_stop_o <= 1'b0;
		end else if (ce_i) begin
			if (limit_hit) begin
				software_limit_alarm_o <= 1'b1;
			end else if (alarm_clear) begin
				software_limit_alarm_o <= 1'b0;
			end
			if (imm_event) begin
				stop_request_o <= 1'b1;
				stop_mode_o <= alarm_stop_sequence;
				immediate_stop_o <= alarm_stop_sequence >= `SPS_IMM_SEQ_MIN;
			end else if (alarm_clear) begin
				stop_request_o <= 1'b0;
				immediate_stop_o <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Falling prevention hold.
	// ****************************************************************
	logic [31:0] step_cnt;
	logic [15:0] hold_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brake_state <= SPS_RUN;
			step_cnt <= 32'h0000_0000;
			hold_cnt <= 16'h0000;
		end else if (ce_i) begin
			unique case (brake_state)
				SPS_RUN: begin
					if (imm_event && alarm_stop_sequence >= `SPS_IMM_SEQ_MIN) begin
						brake_state <= fall_enable ? SPS_HOLD : SPS_STOPPED;
						step_cnt <= 32'h0000_0000;
						hold_cnt <= 16'((17'(brake_hold_wait_time) + 17'h0_0001) >> 1);
					end
				end
				SPS_HOLD: begin
					if (step_cnt == 32'(HOLD_STEP_CYC - 1)) begin
						step_cnt <= 32'h0000_0000;
						hold_cnt <= hold_cnt - 16'h0001;
						if (hold_cnt == 16'h0001) begin
							brake_state <= SPS_STOPPED;
						end
					end else begin
						step_cnt <= step_cnt + 32'h0000_0001;
					end
				end
				SPS_STOPPED: begin
					if (alarm_clear) begin
						brake_state <= SPS_RUN;
					end
				end
				default: brake_state <= SPS_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brake_release_out_o <= 1'b0;
			motor_current_on_o <= 1'b0;
			deviation_clear_o <= 1'b0;
		end else if (ce_i) begin
			brake_release_out_o <= servo_on_i && brake_state == SPS_RUN && !imm_event;
			motor_current_on_o <= (servo_on_i && brake_state == SPS_RUN) || brake_state == SPS_HOLD;
			deviation_clear_o <= brake_state == SPS_HOLD && function_expansion_setup[`SPS_EXP_FALL_BIT];
		end
	end

	// ****************************************************************
	// Warning causes.
	// ****************************************************************
	logic [31:0] fan_cnt;
	logic [7:0] enc_cnt;
	logic [7:0] scale_cnt;
	logic [9:0] cause;
	logic fan_counting;

	assign fan_counting = cause_i.fan_stopped && !(cause_i.upper_fan_idle && !servo_on_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fan_cnt <= 32'h0000_0000;
			enc_cnt <= 8'h00;
			scale_cnt <= 8'h00;
		end else if (ce_i) begin
			if (!fan_counting) begin
				fan_cnt <= 32'h0000_0000;
			end else if (fan_cnt != 32'(FAN_STOP_CYC)) begin
				fan_cnt <= fan_cnt + 32'h0000_0001;
			end
			enc_cnt <= count_err(enc_cnt, cause_i.enc_err, cause_i.enc_ok);
			scale_cnt <= count_err(scale_cnt, cause_i.scale_err, cause_i.scale_ok);
		end
	end

	always_comb begin
		cause = 10'h000;
		cause[0] = cause_i.load_pct >= `SPS_LOAD_WARN_PCT;
		cause[1] = cause_i.regen_pct >= `SPS_LOAD_WARN_PCT;
		cause[2] = cause_i.battery_low;
		cause[3] = fan_counting && fan_cnt == 32'(FAN_STOP_CYC);
		cause[4] = enc_cnt > comm_limit[7:0];
		cause[5] = cause_i.enc_overheat;
		cause[6] = cause_i.vibration > oscillation_detect_level;
		cause[7] = cause_i.lifetime_short;
		cause[8] = cause_i.scale_alarm;
		cause[9] = scale_cnt > comm_limit[15:8];
	end

	// ****************************************************************
	// Warning latching.
	// ****************************************************************
	logic [31:0] sec_cnt;
	logic sec_tick;
	logic [3:0] hold_s [10];
	logic [9:0] held;
	logic [9:0] next_warn;
	logic [3:0] next_code;

	assign sec_tick = sec_cnt == 32'(LATCH_UNIT_CYC - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && sec_tick)) begin
			sec_cnt <= 32'h0000_0000;
		end else if (ce_i) begin
			sec_cnt <= sec_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			held <= 10'h000;
			for (int i = 0; i < 10; i++) begin
				hold_s[i] <= 4'h0;
			end
		end else if (ce_i) begin
			for (int i = 0; i < 10; i++) begin
				if (alarm_clear) begin
					held[i] <= 1'b0;
					hold_s[i] <= 4'h0;
				end else if (cause[i]) begin
					held[i] <= i == `SPS_WARN_BATTERY || i == `SPS_WARN_LIFETIME ||
						(latch_mask[i] && warning_latch_time != 4'h0);
					hold_s[i] <= warning_latch_time;
				end else if (held[i] && sec_tick && i != `SPS_WARN_BATTERY && i != `SPS_WARN_LIFETIME &&
					warning_latch_time <= `SPS_LATCH_MAX_S) begin
					hold_s[i] <= hold_s[i] - 4'h1;
					if (hold_s[i] <= 4'h1) begin
						held[i] <= 1'b0;
					end
				end
			end
		end
	end

	always_comb begin
		next_warn = alarm_clear ? 10'h000 : (cause | held);
		next_code = 4'h0;
		for (int i = 9; i >= 0; i--) begin
			if (next_warn[i]) begin
				next_code = 4'(i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			warnings_o <= 10'h000;
			warning_active_o <= 1'b0;
			warning_code_o <= 4'h0;
		end else if (ce_i) begin
			warnings_o <= next_warn;
			warning_active_o <= next_warn != 10'h000;
			warning_code_o <= next_code;
		end
	end

endmodule
`default_nettype wire

/* File: hw/sps_params.svh */
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define SPS_ADR_WORK_RANGE 8'h00
`define SPS_ADR_SEQUENCE 8'h04
`define SPS_ADR_EXPANSION 8'h08
`define SPS_ADR_BRAKE_HOLD 8'h0C
`define SPS_ADR_WARN_LATCH 8'h10
`define SPS_ADR_OSC_LEVEL 8'h14
`define SPS_ADR_COMM_LIMIT 8'h18
`define SPS_ADR_STATUS 8'h1C
`define SPS_ADR_CMD_MIN 8'h20
`define SPS_ADR_CMD_MAX 8'h24

// ****************************************************************
// Field positions and codes.
// ****************************************************************
`define SPS_SEQ_ALARM_LSB 0
`define SPS_SEQ_OT_LSB 4
`define SPS_EXP_FALL_BIT 10
`define SPS_LATCH_MASK_LSB 16
`define SPS_FALL_SEQ 3'h4
`define SPS_IMM_SEQ_MIN 3'h4
`define SPS_OT_CLEAR_SEQ 3'h2
`define SPS_MODE_POSITION 2'h0
`define SPS_MODE_FULL_CLOSED 2'h3
`define SPS_LOAD_WARN_PCT 8'h55
`define SPS_LATCH_MAX_S 4'hA
`define SPS_WARN_BATTERY 2
`define SPS_WARN_LIFETIME 7

// ****************************************************************
// Reset values.
// ****************************************************************
`define SPS_RST_WORK_RANGE 32'h0000_2710
`define SPS_RST_SEQUENCE 32'h0000_0000
`define SPS_RST_EXPANSION 16'h0000
`define SPS_RST_BRAKE_HOLD 16'h0000
`define SPS_RST_WARN_LATCH 32'h0000_0000
`define SPS_RST_OSC_LEVEL 16'h0000
`define SPS_RST_COMM_LIMIT 16'h0404

// ****************************************************************
// Timing.
// ****************************************************************
`define SPS_CLK_HZ 100000000
`define SPS_HOLD_STEP_MS 2
`define SPS_FAN_STOP_MS 1000
`define SPS_LATCH_UNIT_MS 1000
`define SPS_MS_CYC(ms) ((ms) * (`SPS_CLK_HZ / 1000))

`endif

/* File: hw/sps_pkg.sv */
package sps_pkg;

	// ****************************************************************
	// Shared types.
	// ****************************************************************
	typedef struct packed {
		logic valid;
		logic signed [15:0] delta;
	} sps_cmd_t;

	typedef struct packed {
		logic [7:0] load_pct;
		logic [7:0] regen_pct;
		logic battery_low;
		logic fan_stopped;
		logic upper_fan_idle;
		logic enc_err;
		logic enc_ok;
		logic enc_overheat;
		logic [15:0] vibration;
		logic lifetime_short;
		logic scale_alarm;
		logic scale_err;
		logic scale_ok;
	} sps_cause_t;

	typedef enum logic [1:0] {
		SPS_RUN = 2'b00,
		SPS_HOLD = 2'b01,
		SPS_STOPPED = 2'b11
	} sps_brake_t;

endpackage

/* File: verification/sps_supervisor_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sps_supervisor_sva
	import sps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] control_mode_i,
	input wire logic servo_on_i,
	input wire logic tool_test_i,
	input wire logic alarm_clear_in_i,
	input wire sps_cause_t cause_i,
	input wire logic software_limit_alarm_o,
	input wire logic stop_request_o,
	input wire logic brake_release_out_o,
	input wire logic motor_current_on_o,
	input wire logic deviation_clear_o,
	input wire logic [9:0] warnings_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_alarm_rise;
		$rose(software_limit_alarm_o);
	endsequence
	sequence s_hold_start;
		motor_current_on_o && $fell(brake_release_out_o) ##1 deviation_clear_o;
	endsequence
	sequence s_no_clear;
		!alarm_clear_in_i [*4];
	endsequence
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_mode_gate: assert property (s_alarm_rise |-> $past(control_mode_i) inside {2'h0, 2'h3})
		else $error("limit alarm outside position modes");
	a_servo_gate: assert property (s_alarm_rise |-> $past(servo_on_i))
		else $error("limit alarm with servo off");
	a_tool_gate: assert property (s_alarm_rise |-> !$past(tool_test_i))
		else $error("limit alarm during tool run");
	a_limit_stop: assert property (s_alarm_rise |-> stop_request_o)
		else $error("limit alarm without stop request");
	a_load_warn: assert property (s_no_clear ##0 (cause_i.load_pct >= 8'h55) |=> warnings_o[0])
		else $error("overload warning missing");
	a_regen_warn: assert property (s_no_clear ##0 (cause_i.regen_pct >= 8'h55) |=> warnings_o[1])
		else $error("regeneration warning missing");
	a_clear_hold: assert property (alarm_clear_in_i [*4] |=> warnings_o == 10'h000)
		else $error("warning kept during alarm clear");
	a_hold_current: assert property (s_hold_start |-> motor_current_on_o [*3])
		else $error("current dropped early in hold");
	a_dev_clear: assert property (deviation_clear_o |-> motor_current_on_o)
		else $error("deviation clear outside hold");
	a_fan_cause: assert property ($rose(warnings_o[3]) |-> $past(cause_i.fan_stopped))
		else $error("fan warning without stopped fan");
endmodule
bind sps_supervisor sps_supervisor_sva sps_supervisor_sva_i (.clk_i, .rst_i, .wb_ack_o, .control_mode_i,
	.servo_on_i, .tool_test_i, .alarm_clear_in_i, .cause_i, .software_limit_alarm_o, .stop_request_o,
	.brake_release_out_o, .motor_current_on_o, .deviation_clear_o, .warnings_o);
`default_nettype wire

/* File: verification/sps_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sps_host_model
	import sps_pkg::*;
(
	input wire logic clk_i,
	output sps_cmd_t cmd_o,
	output logic alarm_clear_o
);
	initial begin
		cmd_o = '0;
		alarm_clear_o = 1'b0;
	end
	// Between commands the delta lines show the inverse so stale data is never mistaken for a command.
	task automatic send(input logic signed [15:0] d);
		@(posedge clk_i);
		cmd_o <= '{valid: 1'b1, delta: d};
		@(posedge clk_i);
		cmd_o <= '{valid: 1'b0, delta: ~d};
	endtask
	// The clear is held long enough to pass the pin synchroniser.
	task automatic clear_alarm();
		@(posedge clk_i);
		alarm_clear_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		alarm_clear_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

/* File: verification/tb_sps_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sps_params.svh"
module tb_sps_supervisor
	import sps_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [46:0] req = '0;
	logic [31:0] rdat, dat_o;
	logic wack, servo = 1'b0, tool = 1'b0, imm = 1'b0, sla, sreq, imst, brk, cur, dvc, wact, aclr;
	logic [1:0] mode = 2'h0;
	logic [2:0] pins = 3'h0, smode;
	logic [3:0] wcode;
	logic [9:0] warn;
	logic signed [31:0] pos = 32'sh0000_0000;
	sps_cause_t cause = '0;
	sps_cmd_t cmd;
	int fail_count = 0, comparisons = 0, cp, cmin, cmax, n, e;
	integer seed;
	logic [7:0] l, r;
	sps_supervisor #(.HOLD_STEP_CYC(4), .FAN_STOP_CYC(20), .LATCH_UNIT_CYC(10)) sps_supervisor_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(req[46]), .wb_stb_i(req[45]), .wb_we_i(req[44]),
		.wb_adr_i(req[43:36]), .wb_sel_i(req[35:32]), .wb_dat_i(req[31:0]), .wb_dat_o(dat_o), .wb_ack_o(wack),
		.cmd_i(cmd), .motor_pos_i(pos), .servo_on_i(servo), .control_mode_i(mode), .tool_test_i(tool),
		.trial_run_i(pins[2]), .imm_alarm_i(imm), .cause_i(cause), .alarm_clear_in_i(aclr),
		.dev_clear_in_i(pins[0]), .ot_inhibit_in_i(pins[1]), .software_limit_alarm_o(sla), .stop_request_o(sreq),
		.stop_mode_o(smode), .immediate_stop_o(imst), .brake_release_out_o(brk), .motor_current_on_o(cur),
		.deviation_clear_o(dvc), .warnings_o(warn), .warning_active_o(wact), .warning_code_o(wcode));
	sps_host_model host_i (.clk_i(clk_i), .cmd_o(cmd), .alarm_clear_o(aclr));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ****************************************************************
	// Bus, compare and closing tasks.
	// ****************************************************************
	task automatic tk(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, ex, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= {2'b11, w, a, 4'hF, d};
		do begin
			@(posedge clk_i);
		end while (wack !== 1'b1);
		rdat = dat_o;
		req <= {2'b00, ~w, ~a, 4'h0, ~d};
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		wb(1'b0, a, 32'h0000_0000);
		chk("register", ex, rdat);
	endtask
	task automatic lim(input int p, input logic ex);
		pos <= p;
		tk(3);
		chk("limit alarm", 32'(ex), 32'(sla));
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		test_done();
	end
	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial begin
		int d;
		seed = 32'h74e3d17a;
		tk(2);
		rst_i <= 1'b0;
		rd(`SPS_ADR_WORK_RANGE, `SPS_RST_WORK_RANGE);
		rd(`SPS_ADR_COMM_LIMIT, {16'h0000, `SPS_RST_COMM_LIMIT});
		rd(8'h3C, 32'h0000_0000);
		wb(1'b1, `SPS_ADR_STATUS, 32'hFFFF_FFFF);
		rd(`SPS_ADR_STATUS, 32'h0000_0000);
		$display("test registers done");
		wb(1'b1, `SPS_ADR_WORK_RANGE, 32'h0000_0064);
		for (int c = 0; c < 4; c++) begin
			servo <= (c != 0);
			mode <= (c == 1) ? 2'h1 : (c == 2) ? 2'h2 : 2'h0;
			tool <= (c == 3);
			lim(101, 1'b0);
		end
		servo <= 1'b1;
		mode <= 2'h3;
		tool <= 1'b0;
		lim(100, 1'b0);
		lim(-100, 1'b0);
		lim(-101, 1'b1);
		chk("stop request", 32'h1, 32'(sreq));
		pos <= 0;
		host_i.clear_alarm();
		chk("limit alarm", 32'h0, 32'(sla));
		mode <= 2'h0;
		cp = 0;
		cmin = 0;
		cmax = 0;
		for (int i = 0; i < 12; i++) begin
			d = $random(seed) % 200;
			host_i.send(d[15:0]);
			cp += d;
			cmin = (cp < cmin) ? cp : cmin;
			cmax = (cp > cmax) ? cp : cmax;
		end
		tk(2);
		rd(`SPS_ADR_CMD_MIN, cmin);
		rd(`SPS_ADR_CMD_MAX, cmax);
		lim(cmax + 100, 1'b0);
		lim(cmax + 101, 1'b1);
		pos <= 0;
		host_i.clear_alarm();
		lim(cmin - 101, 1'b1);
		pos <= 0;
		host_i.clear_alarm();
		for (int k = 0; k < 3; k++) begin
			host_i.send(16'sd50);
			if (k == 1) wb(1'b1, `SPS_ADR_SEQUENCE, 32'h0000_0020);
			pins[k] <= 1'b1;
			tk(4);
			if (k < 2) pins[k] <= 1'b0;
			tk(2);
			rd(`SPS_ADR_CMD_MAX, 32'h0000_0000);
		end
		$display("test software limit done");
		for (int i = 0; i < 6; i++) begin
			static logic [2:0] sq [6] = '{3'h3, 3'h4, 3'h5, 3'h7, 3'h4, 3'h4};
			static logic [15:0] hd [6] = '{16'h000B, 16'h000B, 16'h000B, 16'h000B, 16'h0000, 16'h000B};
			logic [5:0] bx;
			logic s;
			logic v;
			bx = 6'b011111;
			s = 1'b0;
			v = 1'b0;
			wb(1'b1, `SPS_ADR_SEQUENCE, {29'h0, sq[i]});
			wb(1'b1, `SPS_ADR_EXPANSION, {21'h0, bx[i], 10'h000});
			wb(1'b1, `SPS_ADR_BRAKE_HOLD, {16'h0000, hd[i]});
			@(posedge clk_i);
			imm <= 1'b1;
			@(posedge clk_i);
			imm <= 1'b0;
			n = 0;
			repeat (60) begin
				@(posedge clk_i);
				n += (cur === 1'b1 && brk === 1'b0);
				s |= (imst === 1'b1);
				v |= (dvc === 1'b1);
			end
			// The brake drops one cycle before the current follows the brake state, so each event adds one cycle.
			e = (sq[i] == 3'h4 && bx[i] && hd[i] != 0) ? ((hd[i] + 1) / 2) * 4 + 1 : 1;
			chk("hold cycles", e, n);
			chk("deviation clear", 32'(e > 1), 32'(v));
			chk("immediate stop", 32'(sq[i] >= 3'h4), 32'(s));
			chk("stop mode", {29'h0, sq[i]}, {29'h0, smode});
			host_i.clear_alarm();
		end
		$display("test falling prevention done");
		for (int i = 0; i < 24; i++) begin
			l = (i < 2) ? 8'h54 + i : $random(seed);
			r = (i < 2) ? 8'h55 - i : $random(seed);
			cause.load_pct <= l;
			cause.regen_pct <= r;
			tk(3);
			chk("load warning", 32'(l >= 8'h55), 32'(warn[0]));
			chk("regen warning", 32'(r >= 8'h55), 32'(warn[1]));
		end
		cause.regen_pct <= 8'h00;
		wb(1'b1, `SPS_ADR_WARN_LATCH, 32'h0001_0002);
		cause.load_pct <= 8'h5A;
		cause.battery_low <= 1'b1;
		tk(3);
		cause.load_pct <= 8'h00;
		cause.battery_low <= 1'b0;
		tk(5);
		chk("latched warning", 32'h1, 32'(warn[0]));
		tk(40);
		chk("latch expiry", 32'h0, 32'(warn[0]));
		chk("battery warning", 32'h1, 32'(warn[2]));
		host_i.clear_alarm();
		chk("battery cleared", 32'h0, 32'(warn[2]));
		cause.fan_stopped <= 1'b1;
		tk(15);
		chk("fan early", 32'h0, 32'(warn[3]));
		tk(10);
		chk("fan warning", 32'h1, 32'(warn[3]));
		cause.fan_stopped <= 1'b0;
		tk(3);
		servo <= 1'b0;
		cause.upper_fan_idle <= 1'b1;
		cause.fan_stopped <= 1'b1;
		tk(30);
		chk("idle fan", 32'h0, 32'(warn[3]));
		cause.fan_stopped <= 1'b0;
		for (int j = 0; j < 5; j++) begin
			@(posedge clk_i);
			{cause.enc_err, cause.scale_err} <= 2'b11;
			@(posedge clk_i);
			{cause.enc_err, cause.scale_err} <= 2'b00;
			tk(2);
			chk("encoder comm", 32'(j == 4), 32'(warn[4]));
			chk("scale comm", 32'(j == 4), 32'(warn[9]));
		end
		{cause.enc_ok, cause.scale_ok} <= 2'b11;
		tk(1);
		{cause.enc_ok, cause.scale_ok} <= 2'b00;
		tk(3);
		for (int k = 0; k < 4; k++) begin
			cause.enc_overheat <= (k == 0);
			cause.vibration <= (k == 1) ? 16'h0001 : 16'h0000;
			cause.scale_alarm <= (k == 2);
			cause.lifetime_short <= (k == 3);
			tk(3);
			e = (k == 0) ? 5 : (k == 1) ? 6 : (k == 2) ? 8 : 7;
			chk("warning set", 32'h1 << e, {22'h0, warn});
			chk("warning code", e, {28'h0, wcode});
			chk("warning active", 32'h1, 32'(wact));
		end
		$display("test warnings done");
		test_done();
	end
endmodule
`default_nettype wire
